// File: tpp_consts.svh
// register indices, reset values and field positions of the test-pattern palette block
`ifndef TPP_CONSTS_SVH
`define TPP_CONSTS_SVH

// register indices; the bus byte address is four times the index
`define TPP_IDX_PAL_ONE_FIX 6'h10
`define TPP_IDX_PAL_ONE 6'h11
`define TPP_IDX_PAL_TWO 6'h12
`define TPP_IDX_PAL_THREE 6'h13
`define TPP_IDX_PAL_FOUR 6'h14
`define TPP_IDX_PAL_FIVE 6'h15
`define TPP_IDX_PAL_SIX 6'h16
`define TPP_IDX_PAL_SEVEN 6'h17
`define TPP_IDX_PAL_EIGHT 6'h18
`define TPP_IDX_PAL_NINE 6'h19
`define TPP_IDX_PAL_TEN 6'h1A
`define TPP_IDX_PAL_ELEVEN 6'h1B
`define TPP_IDX_PAL_TWELVE 6'h1C
`define TPP_IDX_PAL_THIRTEEN 6'h1D
`define TPP_IDX_PAL_FOURTEEN 6'h1E
`define TPP_IDX_UNUSED_SLOT 6'h1F
`define TPP_IDX_CTRL 6'h20
`define TPP_IDX_STATUS 6'h21

// palette reset values
`define TPP_RST_PAL_ONE_FIX 8'h00
`define TPP_RST_PAL_ONE 8'h33
`define TPP_RST_PAL_TWO 8'hF0
`define TPP_RST_PAL_THREE 8'h7F
`define TPP_RST_PAL_FOUR 8'h55
`define TPP_RST_PAL_FIVE 8'hCC
`define TPP_RST_PAL_SIX 8'h0F
`define TPP_RST_PAL_SEVEN 8'h80
`define TPP_RST_PAL_EIGHT 8'h00
`define TPP_RST_PAL_NINE 8'h00
`define TPP_RST_PAL_TEN 8'h00
`define TPP_RST_PAL_ELEVEN 8'h00
`define TPP_RST_PAL_TWELVE 8'h00
`define TPP_RST_PAL_THIRTEEN 8'h00
`define TPP_RST_PAL_FOURTEEN 8'h00
`define TPP_RST_UNUSED_SLOT 8'h00

// control register: reset value and writable bits
`define TPP_CTRL_RST 32'h00000FE0
`define TPP_CTRL_WMASK 32'h00FFFFF3

// pattern geometry
`define TPP_BAR_LAST 3'h7
`define TPP_FIX_LAST_MAX 4'hE

`endif

// File: tpp_pkg.sv
// types shared by the test-pattern palette block
package tpp_pkg;

    typedef enum logic [1:0] {
        TPP_IDLE,
        TPP_BARS,
        TPP_FIXED
    } tpp_state_type;

    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic [7:0] pix_div;
        logic [7:0] bar_last;
        logic [3:0] fixed_last;
        logic [1:0] rsvd_lo;
        logic mode_fixed;
        logic enable;
    } tpp_ctrl_type;

    typedef struct packed {
        logic [15:0] cycles;
        logic [3:0] fix_idx;
        logic [2:0] bar_idx;
        logic [6:0] rsvd;
        logic fixed_mode;
        logic active;
    } tpp_status_type;

    typedef struct packed {
        logic we;
        logic [5:0] idx;
        logic [31:0] wdata;
        logic [3:0] sel;
    } tpp_wb_req_type;

endpackage

// File: tpp_palette_mem.sv
// sixteen-byte palette store, one write/read port for software and one read port for the generator
`timescale 1ns/1ns
`include "tpp_consts.svh"

module tpp_palette_mem
    import tpp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_a_addr,
    output logic [7:0] rd_a_data,
    input wire logic [3:0] rd_b_addr,
    output logic [7:0] rd_b_data
);

    logic [7:0] mem_q [16];
    logic [7:0] mem_d [16];
    logic [7:0] rd_a_d;
    logic [7:0] rd_b_d;

    function automatic logic [7:0] pal_default(input logic [3:0] idx);
        case ({2'h1, idx})
            `TPP_IDX_PAL_ONE_FIX: pal_default = `TPP_RST_PAL_ONE_FIX;
            `TPP_IDX_PAL_ONE: pal_default = `TPP_RST_PAL_ONE;
            `TPP_IDX_PAL_TWO: pal_default = `TPP_RST_PAL_TWO;
            `TPP_IDX_PAL_THREE: pal_default = `TPP_RST_PAL_THREE;
            `TPP_IDX_PAL_FOUR: pal_default = `TPP_RST_PAL_FOUR;
            `TPP_IDX_PAL_FIVE: pal_default = `TPP_RST_PAL_FIVE;
            `TPP_IDX_PAL_SIX: pal_default = `TPP_RST_PAL_SIX;
            `TPP_IDX_PAL_SEVEN: pal_default = `TPP_RST_PAL_SEVEN;
            `TPP_IDX_PAL_EIGHT: pal_default = `TPP_RST_PAL_EIGHT;
            `TPP_IDX_PAL_NINE: pal_default = `TPP_RST_PAL_NINE;
            `TPP_IDX_PAL_TEN: pal_default = `TPP_RST_PAL_TEN;
            `TPP_IDX_PAL_ELEVEN: pal_default = `TPP_RST_PAL_ELEVEN;
            `TPP_IDX_PAL_TWELVE: pal_default = `TPP_RST_PAL_TWELVE;
            `TPP_IDX_PAL_THIRTEEN: pal_default = `TPP_RST_PAL_THIRTEEN;
            `TPP_IDX_PAL_FOURTEEN: pal_default = `TPP_RST_PAL_FOURTEEN;
            default: pal_default = `TPP_RST_UNUSED_SLOT;
        endcase
    endfunction

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            mem_d[i] = (wr_en && wr_addr == 4'(i)) ? wr_data : mem_q[i];
        end
        rd_a_d = mem_q[rd_a_addr];
        rd_b_d = mem_q[rd_b_addr];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= pal_default(4'(i));
            end
            rd_a_data <= 8'h00;
            rd_b_data <= 8'h00;
        end else begin
            mem_q <= mem_d;
            rd_a_data <= rd_a_d;
            rd_b_data <= rd_b_d;
        end
    end

endmodule

// File: tpp_pix_div.sv
// pixel-rate divider: one-cycle enable every (div + 1) clocks
`timescale 1ns/1ns

module tpp_pix_div
    import tpp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [7:0] div,
    output logic pix_en
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic pix_en_d;

    always_comb begin
        pix_en_d = 1'b0;
        cnt_d = cnt_q;
        if (!run) begin
            cnt_d = 8'h00;
        end else if (cnt_q >= div) begin
            cnt_d = 8'h00;
            pix_en_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
            pix_en <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pix_en <= pix_en_d;
        end
    end

endmodule

// File: tpp_palette_top.sv
// test-pattern palette registers on classic wishbone, with the bar and fixed-colour byte generator
//
// Contract
// - colour bar four sends palette_byte_four; it resets to 0x55
// - colour bar five sends palette_byte_five; it resets to 0xCC
// - colour bar six sends palette_byte_six; it resets to 0x0F
// - colour bar seven sends palette_byte_seven; it resets to 0x80
// - fixed pattern byte five comes from palette_byte_four
// - fixed pattern byte six comes from palette_byte_five
// - fixed pattern byte seven comes from palette_byte_six
// - fixed pattern byte eight comes from palette_byte_seven
// - palette_byte_eight feeds fixed byte nine only, never a colour bar
// - palette_byte_nine resets to zero, feeds fixed byte ten only
// - palette_byte_ten feeds fixed byte eleven only
// - palette_byte_eleven resets to zero, feeds fixed byte twelve only
// - palette_byte_twelve resets to zero, feeds fixed byte thirteen only
// - palette_byte_thirteen resets to zero, feeds fixed byte fourteen only
// - palette_byte_fourteen resets to zero, feeds fixed byte fifteen only
// - bars one to three and fixed bytes two to four use the preceding registers
`timescale 1ns/1ns
`include "tpp_consts.svh"

module tpp_palette_top
    import tpp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [31:0] wb_dat_w,
    input wire logic [3:0] wb_sel,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic [7:0] video_byte,
    output logic video_valid,
    output logic video_first,
    output logic pattern_active
);

    // wrap-around increment shared by the pixel, bar and fixed-byte counters
    function automatic logic [7:0] wrap_inc(input logic [7:0] value, input logic [7:0] last);
        if (value >= last) begin
            wrap_inc = 8'h00;
        end else begin
            wrap_inc = value + 8'h01;
        end
    endfunction

    function automatic logic is_palette(input logic [5:0] idx);
        is_palette = (idx >= `TPP_IDX_PAL_ONE_FIX) && (idx <= `TPP_IDX_UNUSED_SLOT);
    endfunction

    // byte-lane merge of a control write; reserved bits always read back as zero
    function automatic logic [31:0] ctrl_merge(input logic [31:0] old, input logic [31:0] wdata,
        input logic [3:0] sel);
        logic [31:0] mask;
        logic [31:0] merged;
        mask = `TPP_CTRL_WMASK;
        merged = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                merged[8*b +: 8] = wdata[8*b +: 8] & mask[8*b +: 8];
            end
        end
        ctrl_merge = merged;
    endfunction

    // ---------------------------------------------------------------
    // bus slave state
    // ---------------------------------------------------------------
    tpp_wb_req_type req;
    logic pend_q;
    logic pend_d;
    logic ack_d;
    logic [31:0] dat_r_d;
    tpp_ctrl_type ctrl_q;
    tpp_ctrl_type ctrl_d;
    tpp_status_type status;

    // ---------------------------------------------------------------
    // generator state
    // ---------------------------------------------------------------
    tpp_state_type state_q;
    tpp_state_type state_d;
    logic [7:0] pix_cnt_q;
    logic [7:0] pix_cnt_d;
    logic [2:0] bar_idx_q;
    logic [2:0] bar_idx_d;
    logic [3:0] fix_idx_q;
    logic [3:0] fix_idx_d;
    logic [15:0] cycles_q;
    logic [15:0] cycles_d;
    logic issue_q;
    logic issue_d;
    logic issue_first_q;
    logic issue_first_d;
    logic [7:0] video_byte_d;
    logic video_valid_d;
    logic video_first_d;
    logic pattern_active_d;

    logic pix_en;
    logic mem_wr_en;
    logic [7:0] pal_rd_a;
    logic [7:0] pal_rd_b;
    logic [3:0] gen_addr;
    logic [3:0] fix_last;

    // ---------------------------------------------------------------
    // request capture
    // ---------------------------------------------------------------
    // the request is held stable by the master until ack, so it is read directly
    assign req.we = wb_we;
    assign req.idx = wb_adr[7:2];
    assign req.wdata = wb_dat_w;
    assign req.sel = wb_sel;

    // the palette write lands on the same edge that raises ack
    assign mem_wr_en = pend_q && req.we && req.sel[0] && is_palette(req.idx);

    tpp_palette_mem u_mem (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr_en(mem_wr_en),
        .wr_addr(req.idx[3:0]),
        .wr_data(req.wdata[7:0]),
        .rd_a_addr(req.idx[3:0]),
        .rd_a_data(pal_rd_a),
        .rd_b_addr(gen_addr),
        .rd_b_data(pal_rd_b)
    );

    tpp_pix_div u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(ctrl_q.enable),
        .div(ctrl_q.pix_div),
        .pix_en(pix_en)
    );

    assign status.cycles = cycles_q;
    assign status.fix_idx = fix_idx_q;
    assign status.bar_idx = bar_idx_q;
    assign status.rsvd = 7'h00;
    assign status.fixed_mode = (state_q == TPP_FIXED);
    assign status.active = (state_q != TPP_IDLE);

    // ---------------------------------------------------------------
    // wishbone classic slave: two wait states, ack for exactly one cycle
    // ---------------------------------------------------------------
    always_comb begin
        pend_d = wb_cyc && wb_stb && !pend_q && !wb_ack;
        ack_d = pend_q && wb_cyc && wb_stb;
        dat_r_d = wb_dat_r;
        ctrl_d = ctrl_q;
        if (pend_q) begin
            dat_r_d = 32'h00000000;
            if (is_palette(req.idx)) begin
                // a write with byte lane zero selected returns the written byte; any other access returns the stored one
                dat_r_d = {24'h000000, (req.we && req.sel[0]) ? req.wdata[7:0] : pal_rd_a};
            end else if (req.idx == `TPP_IDX_CTRL) begin
                if (req.we) begin
                    ctrl_d = ctrl_merge(ctrl_q, req.wdata, req.sel);
                end
                dat_r_d = ctrl_d;
            end else if (req.idx == `TPP_IDX_STATUS) begin
                dat_r_d = status;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_q <= 1'b0;
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h00000000;
            ctrl_q <= `TPP_CTRL_RST;
        end else begin
            pend_q <= pend_d;
            wb_ack <= ack_d;
            wb_dat_r <= dat_r_d;
            ctrl_q <= ctrl_d;
        end
    end

    // ---------------------------------------------------------------
    // pattern sequencing
    // ---------------------------------------------------------------
    // a length of sixteen would reach the reserved slot, so it is clamped to fifteen bytes
    assign fix_last = (ctrl_q.fixed_last > `TPP_FIX_LAST_MAX) ? `TPP_FIX_LAST_MAX : ctrl_q.fixed_last;

    // bar n and fixed byte n+1 share palette slot n; slot zero is fixed byte one
    always_comb begin
        case (state_q)
            TPP_BARS: gen_addr = {1'b0, bar_idx_q};
            TPP_FIXED: gen_addr = fix_idx_q;
            default: gen_addr = 4'h0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        pix_cnt_d = pix_cnt_q;
        bar_idx_d = bar_idx_q;
        fix_idx_d = fix_idx_q;
        cycles_d = cycles_q;
        issue_d = 1'b0;
        issue_first_d = 1'b0;
        case (state_q)
            TPP_IDLE: begin
                pix_cnt_d = 8'h00;
                bar_idx_d = 3'h0;
                fix_idx_d = 4'h0;
                if (ctrl_q.enable) begin
                    state_d = ctrl_q.mode_fixed ? TPP_FIXED : TPP_BARS;
                end
            end
            TPP_BARS: begin
                // bar slots stop at seven, so slots eight upward never show up as a bar
                if (!ctrl_q.enable || ctrl_q.mode_fixed) begin
                    state_d = TPP_IDLE;
                end else if (pix_en) begin
                    issue_d = 1'b1;
                    issue_first_d = (bar_idx_q == 3'h0) && (pix_cnt_q == 8'h00);
                    pix_cnt_d = wrap_inc(pix_cnt_q, ctrl_q.bar_last);
                    if (pix_cnt_q >= ctrl_q.bar_last) begin
                        bar_idx_d = 3'(wrap_inc({5'h00, bar_idx_q}, {5'h00, `TPP_BAR_LAST}));
                        if (bar_idx_q == `TPP_BAR_LAST) begin
                            cycles_d = cycles_q + 16'h0001;
                        end
                    end
                end
            end
            TPP_FIXED: begin
                if (!ctrl_q.enable || !ctrl_q.mode_fixed) begin
                    state_d = TPP_IDLE;
                end else if (pix_en) begin
                    issue_d = 1'b1;
                    issue_first_d = (fix_idx_q == 4'h0);
                    // slots eight to fourteen only ever feed the fixed sequence
                    fix_idx_d = 4'(wrap_inc({4'h0, fix_idx_q}, {4'h0, fix_last}));
                    if (fix_idx_q >= fix_last) begin
                        cycles_d = cycles_q + 16'h0001;
                    end
                end
            end
            default: begin
                state_d = TPP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= TPP_IDLE;
            pix_cnt_q <= 8'h00;
            bar_idx_q <= 3'h0;
            fix_idx_q <= 4'h0;
            cycles_q <= 16'h0000;
            issue_q <= 1'b0;
            issue_first_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pix_cnt_q <= pix_cnt_d;
            bar_idx_q <= bar_idx_d;
            fix_idx_q <= fix_idx_d;
            cycles_q <= cycles_d;
            issue_q <= issue_d;
            issue_first_q <= issue_first_d;
        end
    end

    // ---------------------------------------------------------------
    // video output stage
    // ---------------------------------------------------------------
    // the palette read port registers on the issuing edge, so its data is ready one cycle later;
    // a palette write takes effect on the next byte issued, never in the middle of one
    always_comb begin
        video_byte_d = video_byte;
        video_valid_d = 1'b0;
        video_first_d = 1'b0;
        pattern_active_d = (state_d != TPP_IDLE);
        if (issue_q && state_q != TPP_IDLE) begin
            video_byte_d = pal_rd_b;
            video_valid_d = 1'b1;
            video_first_d = issue_first_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            video_byte <= 8'h00;
            video_valid <= 1'b0;
            video_first <= 1'b0;
            pattern_active <= 1'b0;
        end else begin
            video_byte <= video_byte_d;
            video_valid <= video_valid_d;
            video_first <= video_first_d;
            pattern_active <= pattern_active_d;
        end
    end

endmodule

// File: tpp_palette_sva.sv
// assertions on the palette register bank ports and its pattern output
`timescale 1ns/1ns
module tpp_palette_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [31:0] wb_dat_w,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    input wire logic [7:0] video_byte,
    input wire logic video_valid,
    input wire logic video_first,
    input wire logic pattern_active
);
    localparam logic [7:0] RST_VAL [16] = '{8'h00, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F, 8'h80,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] shd_q [16];
    logic [7:0] shd_d [16];
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    logic [7:0] pos_q;
    logic [7:0] pos_d;
    logic [7:0] bl_q;
    logic [7:0] bl_d;
    logic fix_q;
    logic fix_d;
    logic [5:0] idx;
    logic [7:0] cur;
    logic [8:0] exp_idx;

    assign idx = wb_adr[7:2];
    assign cur = video_first ? 8'h00 : pos_q + 8'h01;
    // mode is latched at the first byte so bytes still in flight after a mode change stay judged by the old one
    assign exp_idx = fix_q ? {1'b0, cur} : {1'b0, cur} / ({1'b0, bl_q} + 9'h001);

    always_comb begin
        shd_d = shd_q;
        ctl_d = ctl_q;
        pos_d = pos_q;
        bl_d = bl_q;
        fix_d = fix_q;
        if (wb_ack && wb_we && wb_sel[0] && idx[5:4] == 2'h1) begin
            shd_d[idx[3:0]] = wb_dat_w[7:0];
        end
        // only full-word control writes are tracked
        if (wb_ack && wb_we && wb_sel == 4'hF && idx == 6'h20) begin
            ctl_d = wb_dat_w;
        end
        if (video_valid) begin
            pos_d = cur;
        end
        if (video_valid && video_first) begin
            fix_d = ctl_q[1];
            bl_d = ctl_q[15:8];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shd_q <= RST_VAL;
            ctl_q <= 32'h00000FE0;
            pos_q <= 8'h00;
            bl_q <= 8'h00;
            fix_q <= 1'b0;
        end else begin
            shd_q <= shd_d;
            ctl_q <= ctl_d;
            pos_q <= pos_d;
            bl_q <= bl_d;
            fix_q <= fix_d;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_ack_single_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");
    a_ack_two_after: assert property ($rose(wb_cyc && wb_stb) |-> ##2 wb_ack)
        else $error("ack did not follow the request after two edges");
    a_ack_has_cause: assert property (wb_ack |-> $past(wb_cyc && wb_stb) && $past(wb_cyc && wb_stb, 2))
        else $error("ack without a held request");
    a_rdata_held: assert property ($fell(wb_ack) |-> $stable(wb_dat_r))
        else $error("read data changed as ack fell");
    a_pal_readback: assert property (wb_ack && !wb_we && idx[5:4] == 2'h1
        |-> wb_dat_r[7:0] == shd_q[idx[3:0]])
        else $error("palette read differs from last write or default");
    a_unmapped_zero: assert property (wb_ack && !wb_we && idx > 6'h21 |-> wb_dat_r == 32'h00000000)
        else $error("unmapped read not zero");
    a_first_is_valid: assert property (video_first |-> video_valid)
        else $error("first marker without a byte");
    a_video_from_pal: assert property (video_valid && exp_idx < 9'h010
        |-> video_byte == shd_q[exp_idx[3:0]])
        else $error("pattern byte not from its palette register");
    a_video_when_active: assert property (video_valid |-> pattern_active || $past(pattern_active)
        || $past(pattern_active, 2) || $past(pattern_active, 3))
        else $error("byte issued while generator idle");

    c_read_ack: cover property (wb_ack && !wb_we);
    c_fixed_start: cover property (video_first && fix_d);
    c_bar_start: cover property (video_first && !fix_d);
endmodule

bind tpp_palette_top tpp_palette_sva i_sva (.ref_clk, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_dat_w,
    .wb_sel, .wb_dat_r, .wb_ack, .video_byte, .video_valid, .video_first, .pattern_active);

// File: tb_top.sv
// self-checking bench for the palette registers and the pattern bytes they feed
`timescale 1ns/1ns
module tb_top;
    import tpp_pkg::*;
    localparam logic [7:0] RST_VAL [16] = '{8'h00, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F, 8'h80,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic ref_clk;
    logic rst;
    logic wb_cyc;
    logic wb_stb;
    logic wb_we;
    logic [7:0] wb_adr;
    logic [31:0] wb_dat_w;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic [7:0] video_byte;
    logic video_valid;
    logic video_first;
    logic pattern_active;
    logic [7:0] pal [16];
    logic [31:0] rd;
    int errors;
    int cmp_count;
    int cycles;

    tpp_palette_top i_dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_sel(wb_sel), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .video_byte(video_byte), .video_valid(video_valid), .video_first(video_first),
        .pattern_active(pattern_active));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ack is a flop output, so reading it right after the edge gives the value sampled there
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        wb_sel <= sel;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_dat_r;
        if (n >= 50) cmp("bus ack", 32'h00000001, 32'h00000000);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic grab(input int num, input int per_bar);
        int n;
        int got;
        n = 0;
        got = 0;
        while (got < num && n < 2000) begin
            @(posedge ref_clk);
            n++;
            if (video_valid === 1'b1 && (got > 0 || video_first === 1'b1)) begin
                cmp("video byte", {24'h000000, pal[got / per_bar]}, {24'h000000, video_byte});
                got++;
            end
        end
        cmp("video byte count", 32'(num), 32'(got));
    endtask

    task automatic t_reset;
        for (int i = 0; i < 16; i++) begin
            bus(1'b0, 8'(8'h40 + i * 4), 32'h00000000, 4'hF);
            if (i < 8) begin
                cmp("reset value", 32'(RST_VAL[i]), 32'(rd[7:0]));
            end else begin
                cmp("reset value", 32'(RST_VAL[i]), 32'(rd[7:0]));
            end
        end
        bus(1'b0, 8'h80, 32'h00000000, 4'hF);
        cmp("ctrl reset", 32'h00000FE0, rd);
        $display("test reset values done");
    endtask

    task automatic t_readback;
        for (int i = 0; i < 16; i++) begin
            pal[i] = 8'(i * 8'h25 + 8'h0B);
            bus(1'b1, 8'(8'h40 + i * 4), {24'hFFFFFF, pal[i]}, 4'hF);
        end
        bus(1'b1, 8'h50, 32'h000000FF, 4'hE);
        for (int i = 0; i < 16; i++) begin
            bus(1'b0, 8'(8'h40 + i * 4), 32'h00000000, 4'hF);
            cmp("readback", {24'h000000, pal[i]}, {24'h000000, rd[7:0]});
        end
        bus(1'b1, 8'hFC, 32'h12345678, 4'hF);
        bus(1'b0, 8'hFC, 32'h00000000, 4'hF);
        cmp("unmapped read", 32'h00000000, rd);
        $display("test readback done");
    endtask

    task automatic t_patterns;
        // two bytes per bar with the divider at one, so bar boundaries and pacing both show
        bus(1'b1, 8'h80, 32'h00010101, 4'hF);
        cmp("ctrl write", 32'h00010101, rd);
        grab(16, 2);
        cmp("pattern active", 32'h00000001, 32'(pattern_active));
        // switching mode while running must restart at fixed byte one; reserved control bits read back as zero
        bus(1'b1, 8'h80, 32'hFF0000FF, 4'hF);
        cmp("ctrl write", 32'h000000F3, rd);
        grab(15, 1);
        bus(1'b0, 8'h84, 32'h00000000, 4'hF);
        cmp("status mode", 32'h00000003, 32'(rd[1:0]));
        bus(1'b1, 8'h80, 32'h00000000, 4'hF);
        cmp("pattern active", 32'h00000000, 32'(pattern_active));
        $display("test patterns done");
    endtask

    initial begin
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        rst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_dat_w = 32'h00000000;
        wb_sel = 4'h0;
        pal = RST_VAL;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_readback();
        t_patterns();
        end_of_test();
    end
endmodule
